// [rtl/ctm_mode_ctrl.sv]
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
// Operation
// - Stay Listen-only while TXD low or select 01 with supply under 90%.
// - Offline grounds bus; watch for wake only when wake enable is 1.
// - Offline goes to Bias on activity; back to Offline after silence.
// - Leaving Normal or select 00: Offline if silent, else Bias first.
// - Active drops on 01 with under 90% or 10 with under reset.
// - Chip Off/Overtemp to Reset puts transceiver in Offline.
// - Offline to Bias on wake pattern or Normal 01 with under 90% or 10 with under reset.
// - Off state, bus floating, on chip Off/Overtemp or battery low.
// - Leave Off into Offline once battery good and chip not Off/Overtemp.
// - Never enter Active while TXD is held low.
// - Monitor wake pattern in Offline or Bias, enabled, selective or valid off.
// - Wake: dominant, recessive, dominant with minimums in window.
// - Valid wake sets wake event flag and drives receive low.
// - Wake during Sleep enables supply and requests Standby via Reset.
// - Mode field 1:0 selects Offline/Active/Listen, only in Normal.
// - Control bit 4 enables selective wake-up.
// - Control bit 5 marks partial-network config valid.
// - Control bit 6 enables FD tolerance, ignored where absent.
// - Status bit 7 is 1 only in Active.
// - Status bit 6 is error or not valid; bit 5 is config valid.
// - Status bit 4 oscillator ok; bit 3 bus silent.
// - Status bit 1 under 90% with select 01; bit 0 TX timeout.
// - Active requested with TXD low gives Listen-only from Active or Listen, else stays Offline/Bias, until TXD high.
// - Select 01 checks 90% level; 10 runs until reset level.
module ctm_mode_ctrl
    import ctm_pkg::*;
#(
    parameter int SILENCE_US = 1000000,
    parameter int WAKE_WINDOW_US = 1000
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Pins and analog comparators
    input wire logic txdIn,
    input wire logic busRxIn,
    input wire logic mcuSupplyUnder90,
    input wire logic mcuSupplyUnderReset,
    input wire logic batUnder,
    // Chip-level logic
    input wire logic [2:0] chipModeCode,
    input wire logic frameDetectError,
    input wire logic pnOscOk,
    input wire logic txTimeout,
    // Transceiver controls
    output ctm_bus_s busCtl,
    output logic fdToleranceEnable,
    output logic selectiveWakeEnable
);

    // =========================================================
    // Derived counts
    localparam int SIL_CYC = SILENCE_US * CLK_MHZ;
    localparam int WIN_CYC = WAKE_WINDOW_US * CLK_MHZ;

    // =========================================================
    // State
    typedef struct packed {
        logic [1:0] txdS;
        logic [2:0] rxS;
        logic [1:0] u90S;
        logic [1:0] uRstS;
        logic [1:0] batS;
        ctm_xcvr_e xs;
        ctm_wake_e ws;
        logic [31:0] silCnt;
        logic silent;
        logic [15:0] phCnt;
        logic [31:0] winCnt;
        logic [7:0] ctrl;
        logic wakeEn;
        logic wakeEvt;
        logic dWrite;
        logic [7:0] dIdx;
        logic [31:0] rdata;
        logic ready;
        ctm_bus_s bus;
    } ctm_state_s;

    ctm_state_s r;
    ctm_state_s nxt;
    logic [1:0] rstSync;

    // =========================================================
    // Helpers
    function automatic ctm_xcvr_e dropTo(input logic quiet);
        dropTo = quiet ? X_OFFLINE : X_BIAS;
    endfunction

    function automatic logic [7:0] regIdx(input logic [31:0] a);
        regIdx = a[9:2];
    endfunction

    // Shared decodes
    logic txdLow;
    logic rxDom;
    logic busEdge;
    logic under90;
    logic underRst;
    logic offCond;
    logic normal;
    logic [1:0] sel;
    logic activeOk;
    logic uvDrop;
    logic monitorEn;
    logic wakeHit;
    logic addrPh;

    assign txdLow = ~r.txdS[1];
    assign rxDom = ~r.rxS[1];
    assign busEdge = r.rxS[1] ^ r.rxS[2];
    assign under90 = r.u90S[1];
    assign underRst = r.uRstS[1];
    assign offCond = r.batS[1] | (chipModeCode == CHIP_OFF)
        | (chipModeCode == CHIP_OVERTEMP);
    assign normal = chipModeCode == CHIP_NORMAL;
    assign sel = r.ctrl[MODE_LSB +: 2];
    assign activeOk = normal & (((sel == SEL_ACT_UV) & ~under90)
        | ((sel == SEL_ACT_RST) & ~underRst));
    assign uvDrop = normal & (((sel == SEL_ACT_UV) & under90)
        | ((sel == SEL_ACT_RST) & underRst));
    assign monitorEn = ((r.xs == X_OFFLINE) | (r.xs == X_BIAS)) & r.wakeEn
        & (~r.ctrl[SELWAKE_BIT] | ~r.ctrl[CFGVALID_BIT]);
    assign wakeHit = (r.ws == W_DOM2) & rxDom
        & (r.phCnt == 16'(WAKE_DOM_CYC - 1));
    assign addrPh = hsel & htrans[1] & hready;

    // =========================================================
    // Reset release
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rstSync <= 2'h0;
        end else begin
            rstSync <= {rstSync[0], 1'b1};
        end
    end

    // =========================================================
    // Next-state logic
    always_comb begin
        logic [31:0] status;
        nxt = r;
        status = 32'h0;
        // Input synchronisers
        nxt.txdS = {r.txdS[0], txdIn};
        nxt.rxS = {r.rxS[1:0], busRxIn};
        nxt.u90S = {r.u90S[0], mcuSupplyUnder90};
        nxt.uRstS = {r.uRstS[0], mcuSupplyUnderReset};
        nxt.batS = {r.batS[0], batUnder};

        // Silence timer
        if (busEdge) begin
            nxt.silCnt = 32'h0;
            nxt.silent = 1'b0;
        end else if (r.silCnt >= 32'(SIL_CYC - 1)) begin
            nxt.silent = 1'b1;
        end else begin
            nxt.silCnt = r.silCnt + 32'h1;
        end

        // Transceiver mode
        if (offCond) begin
            nxt.xs = X_OFF;
        end else begin
            unique case (r.xs)
                X_OFF: begin
                    nxt.xs = X_OFFLINE;
                end
                X_OFFLINE, X_BIAS: begin
                    if (normal && !txdLow && sel == SEL_LISTEN) begin
                        nxt.xs = X_LISTEN;
                    end else if (activeOk && !txdLow) begin
                        nxt.xs = X_ACTIVE;
                    end else if (r.xs == X_OFFLINE) begin
                        if (wakeHit || busEdge || uvDrop) begin
                            nxt.xs = X_BIAS;
                        end
                    end else if (r.silent && !uvDrop) begin
                        // Undervoltage select would pull it straight back
                        nxt.xs = X_OFFLINE;
                    end
                end
                X_LISTEN, X_ACTIVE: begin
                    if (!normal || sel == SEL_OFFLINE) begin
                        nxt.xs = dropTo(r.silent);
                    end else if (sel == SEL_LISTEN) begin
                        nxt.xs = X_LISTEN;
                    end else if (r.xs == X_LISTEN && sel == SEL_ACT_UV
                            && under90) begin
                        nxt.xs = X_LISTEN;
                    end else if (uvDrop) begin
                        nxt.xs = dropTo(r.silent);
                    end else if (txdLow) begin
                        nxt.xs = X_LISTEN;
                    end else begin
                        nxt.xs = X_ACTIVE;
                    end
                end
                default: begin
                    nxt.xs = X_OFFLINE;
                end
            endcase
        end

        // Standard wake pattern detector
        if (r.ws != W_DOM1 && r.ws != W_IDLE) begin
            nxt.winCnt = r.winCnt + 32'h1;
        end
        if (!monitorEn) begin
            nxt.ws = W_IDLE;
            nxt.phCnt = 16'h0;
        end else if (r.ws != W_IDLE && r.ws != W_DOM1
                && r.winCnt >= 32'(WIN_CYC - 1)) begin
            nxt.ws = W_IDLE;
            nxt.phCnt = 16'h0;
        end else begin
            unique case (r.ws)
                W_IDLE: begin
                    nxt.phCnt = 16'h0;
                    if (rxDom) begin
                        nxt.ws = W_DOM1;
                    end
                end
                W_DOM1: begin
                    if (!rxDom) begin
                        nxt.ws = W_IDLE;
                    end else if (r.phCnt == 16'(WAKE_DOM_CYC - 1)) begin
                        nxt.ws = W_REC;
                        nxt.phCnt = 16'h0;
                        nxt.winCnt = 32'h0;
                    end else begin
                        nxt.phCnt = r.phCnt + 16'h1;
                    end
                end
                W_REC: begin
                    if (rxDom) begin
                        nxt.phCnt = 16'h0;
                    end else if (r.phCnt == 16'(WAKE_REC_CYC - 1)) begin
                        nxt.ws = W_DOM2;
                        nxt.phCnt = 16'h0;
                    end else begin
                        nxt.phCnt = r.phCnt + 16'h1;
                    end
                end
                W_DOM2: begin
                    if (!rxDom) begin
                        nxt.phCnt = 16'h0;
                    end else if (wakeHit) begin
                        nxt.ws = W_IDLE;
                        nxt.phCnt = 16'h0;
                    end else begin
                        nxt.phCnt = r.phCnt + 16'h1;
                    end
                end
            endcase
        end

        // Status word
        status[ST_ACTIVE] = r.xs == X_ACTIVE;
        status[ST_PNERR] = frameDetectError | ~r.ctrl[CFGVALID_BIT];
        status[ST_CFGOK] = r.ctrl[CFGVALID_BIT];
        status[ST_OSCOK] = pnOscOk;
        status[ST_SILENT] = r.silent;
        status[ST_V1UNDER] = under90 & (sel == SEL_ACT_UV);
        status[ST_TXTO] = txTimeout;

        // Bus slave: address phase, then data phase
        nxt.ready = 1'b1;
        nxt.dWrite = addrPh & hwrite;
        nxt.dIdx = regIdx(haddr);
        if (addrPh && !hwrite) begin
            unique case (regIdx(haddr))
                CTRL_IDX: nxt.rdata = {24'h0, r.ctrl};
                STAT_IDX: nxt.rdata = status;
                WAKE_IDX: nxt.rdata = {30'h0, r.wakeEn, r.wakeEvt};
                default: nxt.rdata = 32'h0;
            endcase
        end
        if (r.dWrite && r.dIdx == CTRL_IDX) begin
            nxt.ctrl = hwdata[7:0] & CTRL_WMASK;
        end
        if (r.dWrite && r.dIdx == WAKE_IDX) begin
            nxt.wakeEn = hwdata[WK_ENABLE];
            if (hwdata[WK_EVENT]) begin
                nxt.wakeEvt = 1'b0;
            end
        end
        if (wakeHit) begin
            nxt.wakeEvt = 1'b1;
        end

        // Bus-side outputs
        nxt.bus.txEnable = nxt.xs == X_ACTIVE;
        nxt.bus.biasMid = (nxt.xs == X_BIAS) | (nxt.xs == X_LISTEN)
            | (nxt.xs == X_ACTIVE);
        nxt.bus.biasGnd = nxt.xs == X_OFFLINE;
        nxt.bus.rxDriveLow = nxt.wakeEvt;
        nxt.bus.mcuSupplyOn = wakeHit & (chipModeCode == CHIP_SLEEP);
        nxt.bus.chipWakeReq = wakeHit & (chipModeCode == CHIP_SLEEP);
    end

    // =========================================================
    // State register
    always_ff @(posedge ref_clk or negedge rstSync[1]) begin
        if (!rstSync[1]) begin
            r <= '{txdS: 2'h3, rxS: 3'h7, u90S: 2'h0, uRstS: 2'h0,
                batS: 2'h0, xs: X_OFF, ws: W_IDLE, silCnt: 32'h0,
                silent: 1'b0, phCnt: 16'h0, winCnt: 32'h0,
                ctrl: CTRL_RESET, wakeEn: 1'b0, wakeEvt: 1'b0,
                dWrite: 1'b0, dIdx: 8'h0, rdata: 32'h0, ready: 1'b0,
                bus: '0};
        end else begin
            r <= nxt;
        end
    end

    // Outputs
    assign hrdata = r.rdata;
    assign hreadyout = r.ready;
    assign hresp = 1'b0;
    assign busCtl = r.bus;
    assign fdToleranceEnable = r.ctrl[FDTOL_BIT];
    assign selectiveWakeEnable = r.ctrl[SELWAKE_BIT];

    // =========================================================
    // Assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstSync[1]);

    a_off_battery: assert property (r.batS[1] |=> r.xs == X_OFF)
        else $error("battery low did not force off");
    a_no_active_txd: assert property (
        !r.txdS[1] && r.xs != X_ACTIVE |=> r.xs != X_ACTIVE)
        else $error("entered active with txd low");
    a_bias_quiet: assert property (
        r.xs == X_BIAS && r.silent && !offCond && !normal
        |=> r.xs == X_OFFLINE)
        else $error("bias did not return to offline");
    a_edge_bias: assert property (
        r.xs == X_OFFLINE && busEdge && !offCond && !normal
        |=> r.xs == X_BIAS && r.bus.biasMid)
        else $error("bus activity did not bias");
    a_wake_flag: assert property (
        wakeHit |=> r.wakeEvt && r.bus.rxDriveLow)
        else $error("wake did not set flag");
    a_wake_gate: assert property (!monitorEn |=> r.ws == W_IDLE)
        else $error("wake detector ran while disabled");
    a_sleep_wake: assert property (
        wakeHit && chipModeCode == CHIP_SLEEP
        |=> r.bus.mcuSupplyOn ##1 !r.bus.mcuSupplyOn)
        else $error("sleep wake supply pulse wrong");
    a_active_normal: assert property (
        r.xs == X_ACTIVE |-> $past(normal) && r.bus.txEnable)
        else $error("active outside normal");
    a_silence_count: assert property (
        busEdge |=> !r.silent [*4])
        else $error("silence flag too early");
    a_dom_phase: assert property (
        r.ws == W_DOM1 && $past(r.ws) == W_IDLE |-> $past(rxDom))
        else $error("wake started without dominant");

    c_active: cover property (r.xs == X_LISTEN ##1 r.xs == X_ACTIVE);
    c_wake: cover property (wakeHit);
    c_quiet: cover property (r.xs == X_BIAS ##1 r.xs == X_OFFLINE);

endmodule

// [rtl/ctm_pkg.sv]
package ctm_pkg;

    // =========================================================
    // Register map (printed offsets are indices, byte = 4 x idx)
    localparam logic [7:0] CTRL_IDX = 8'h20;
    localparam logic [7:0] STAT_IDX = 8'h22;
    localparam logic [7:0] WAKE_IDX = 8'h24;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Control register fields
    localparam int MODE_LSB = 0;
    localparam int SELWAKE_BIT = 4;
    localparam int CFGVALID_BIT = 5;
    localparam int FDTOL_BIT = 6;
    localparam logic [7:0] CTRL_WMASK = 8'hF3;

    // Status register fields
    localparam int ST_ACTIVE = 7;
    localparam int ST_PNERR = 6;
    localparam int ST_CFGOK = 5;
    localparam int ST_OSCOK = 4;
    localparam int ST_SILENT = 3;
    localparam int ST_V1UNDER = 1;
    localparam int ST_TXTO = 0;

    // Wake register fields
    localparam int WK_EVENT = 0;
    localparam int WK_ENABLE = 1;

    // Mode select values
    localparam logic [1:0] SEL_OFFLINE = 2'h0;
    localparam logic [1:0] SEL_ACT_UV = 2'h1;
    localparam logic [1:0] SEL_ACT_RST = 2'h2;
    localparam logic [1:0] SEL_LISTEN = 2'h3;

    // Chip operating mode codes
    localparam logic [2:0] CHIP_OFF = 3'h0;
    localparam logic [2:0] CHIP_SLEEP = 3'h1;
    localparam logic [2:0] CHIP_OVERTEMP = 3'h2;
    localparam logic [2:0] CHIP_RESET = 3'h3;
    localparam logic [2:0] CHIP_STANDBY = 3'h4;
    localparam logic [2:0] CHIP_NORMAL = 3'h7;

    // Timing
    localparam int CLK_MHZ = 100;
    localparam int WAKE_DOM_NS = 500;
    localparam int WAKE_REC_NS = 500;
    localparam int WAKE_DOM_CYC = (WAKE_DOM_NS * CLK_MHZ + 999) / 1000;
    localparam int WAKE_REC_CYC = (WAKE_REC_NS * CLK_MHZ + 999) / 1000;

    // Transceiver and wake detector states
    typedef enum logic [2:0] {
        X_OFF, X_OFFLINE, X_BIAS, X_LISTEN, X_ACTIVE
    } ctm_xcvr_e;

    typedef enum logic [1:0] {
        W_IDLE, W_DOM1, W_REC, W_DOM2
    } ctm_wake_e;

    // Bus-side outputs
    typedef struct packed {
        logic txEnable;
        logic biasMid;
        logic biasGnd;
        logic rxDriveLow;
        logic mcuSupplyOn;
        logic chipWakeReq;
    } ctm_bus_s;

endpackage

// [verification/ctm_bus_node.sv]
`timescale 1ns/100ps
module ctm_bus_node (
    // Clock
    input wire logic ref_clk,
    // Receiver output and host transmit pin
    output logic busRx,
    output logic txd
);
    // Bus idles recessive, host idles high
    initial begin
        busRx = 1'b1;
        txd = 1'b1;
    end

    // Host controller holds its transmit pin
    task automatic setTxd(input logic v);
        @(posedge ref_clk);
        txd <= v;
    endtask

    // Hold one bus level for n cycles
    task automatic hold(input logic v, input int n);
        busRx <= v;
        repeat (n) @(posedge ref_clk);
    endtask

    // Short traffic burst of bus edges
    task automatic burst(input int n);
        @(posedge ref_clk);
        repeat (n) begin
            hold(1'b0, 3);
            hold(1'b1, 3);
        end
    endtask

    // Dominant, recessive with a stray pulse, dominant
    task automatic wake(input int n);
        @(posedge ref_clk);
        hold(1'b0, n);
        hold(1'b1, n);
        hold(1'b0, 2);
        hold(1'b1, n);
        hold(1'b0, n);
        hold(1'b1, 1);
    endtask
endmodule

// [verification/tb_top.sv]
`timescale 1ns/100ps
module tb_top
    import ctm_pkg::*;
;
    // ==========================================
    // Bench signals
    localparam int SIL = 2 * CLK_MHZ + 50;
    localparam logic [2:0] L_ACT = 3'h6;
    localparam logic [2:0] L_MID = 3'h2;
    localparam logic [2:0] L_GND = 3'h1;
    localparam logic [2:0] L_OFF = 3'h0;
    localparam logic [2:0][7:0] WK = {8'h02, 8'h02, 8'h00};
    localparam logic [2:0][7:0] WC = {8'h20, 8'h30, 8'h20};
    localparam logic [2:0] WHIT = 3'b100;
    localparam logic [2:0][7:0] SC = {8'h00, 8'h20, 8'h20};
    localparam logic [2:0][7:0] SE = {8'h48, 8'h68, 8'h39};
    localparam logic [2:0] SF = 3'b110;
    localparam logic [2:0] SO = 3'b001;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic txdIn;
    logic busRxIn;
    logic under90 = 1'b0;
    logic underRst = 1'b0;
    logic batUnder = 1'b0;
    logic [2:0] chipMode = CHIP_OFF;
    logic fde = 1'b0;
    logic oscOk = 1'b0;
    logic txTo = 1'b0;
    ctm_bus_s busCtl;
    logic fdTol;
    logic selWake;
    logic [2:0] lineSt;
    logic [31:0] rdSnap;
    int nSup = 0;
    int nWake = 0;
    int supBase = 0;
    int wakeBase = 0;
    int n_fail = 0;
    int n_tests = 0;

    // ==========================================
    // Design, far side and clock
    ctm_mode_ctrl #(.SILENCE_US(2), .WAKE_WINDOW_US(5)) dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .txdIn(txdIn),
        .busRxIn(busRxIn), .mcuSupplyUnder90(under90),
        .mcuSupplyUnderReset(underRst), .batUnder(batUnder),
        .chipModeCode(chipMode), .frameDetectError(fde),
        .pnOscOk(oscOk), .txTimeout(txTo), .busCtl(busCtl),
        .fdToleranceEnable(fdTol), .selectiveWakeEnable(selWake)
    );
    ctm_bus_node node (.ref_clk(ref_clk), .busRx(busRxIn), .txd(txdIn));
    always #5 ref_clk = ~ref_clk;
    assign lineSt = {busCtl.txEnable, busCtl.biasMid, busCtl.biasGnd};

    // Count one-cycle wake pulses
    always @(posedge ref_clk) begin
        if (busCtl.mcuSupplyOn === 1'b1)
            nSup++;
        if (busCtl.chipWakeReq === 1'b1)
            nWake++;
    end

    // ==========================================
    // Tasks
    task automatic close_out();
        $display("Compares %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] sn, ev);
        n_tests++;
        if (sn !== ev) begin
            n_fail++;
            $display("MISMATCH %s expected %0h seen %0h", nm, ev, sn);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Wait for hready high at a rising edge, bounded
    task automatic waitRdy();
        int k;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 100);
        if (hreadyout !== 1'b1) begin
            n_fail++;
            $display("MISMATCH hreadyout expected 1 seen timeout");
            close_out();
        end else begin
            rdSnap = hrdata;
        end
    endtask

    // One single word transfer
    task automatic ahb(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hsize <= 3'h2;
        hwrite <= wr;
        haddr <= {22'h0, idx, 2'h0};
        waitRdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        waitRdy();
    endtask

    task automatic rdc(input string nm, input logic [7:0] idx,
                       input logic [7:0] msk, input logic [7:0] ev);
        ahb(1'b0, idx, 32'h0);
        chk(nm, rdSnap & {24'h0, msk}, {24'h0, ev});
    endtask

    // Bus line state settled mid-cycle
    task automatic lines(input logic [2:0] ev);
        @(negedge ref_clk);
        chk("lines", 32'(lineSt), 32'(ev));
        @(posedge ref_clk);
    endtask

    task automatic done(input string nm);
        $display("Test %s done, mismatches so far %0d", nm, n_fail);
    endtask

    // ==========================================
    // Main sequence
    initial begin
        wt(20);
        rst_b <= 1'b1;
        wt(5);
        lines(L_OFF);
        chipMode <= CHIP_RESET;
        wt(4);
        lines(L_GND);
        done("reset");
        // Control register access kinds
        rdc("ctrl", CTRL_IDX, 8'hFF, CTRL_RESET);
        ahb(1'b1, CTRL_IDX, 32'hFF);
        rdc("ctrl", CTRL_IDX, 8'hFF, CTRL_WMASK);
        chk("fdTol", 32'(fdTol), 32'h1);
        chk("selWake", 32'(selWake), 32'h1);
        ahb(1'b1, 8'h21, 32'hFF);
        rdc("unmapped", 8'h21, 8'hFF, 8'h00);
        chk("hresp", 32'(hresp), 32'h0);
        done("registers");
        // Status bits from flags and config valid
        wt(SIL);
        for (int i = 0; i < 3; i++) begin
            fde <= SF[i];
            oscOk <= SO[i];
            txTo <= SO[i];
            ahb(1'b1, CTRL_IDX, {24'h0, SC[i]});
            wt(2);
            rdc("status", STAT_IDX, 8'hFB, SE[i]);
        end
        fde <= 1'b0;
        oscOk <= 1'b0;
        txTo <= 1'b0;
        done("status");
        // Active, undervoltage and stuck transmit pin
        chipMode <= CHIP_NORMAL;
        ahb(1'b1, CTRL_IDX, 32'h21);
        wt(4);
        lines(L_ACT);
        rdc("status", STAT_IDX, 8'h82, 8'h80);
        under90 <= 1'b1;
        wt(4);
        lines(L_MID);
        rdc("status", STAT_IDX, 8'h82, 8'h02);
        ahb(1'b1, CTRL_IDX, 32'h22);
        wt(4);
        lines(L_ACT);
        rdc("status", STAT_IDX, 8'h82, 8'h80);
        underRst <= 1'b1;
        wt(4);
        lines(L_MID);
        under90 <= 1'b0;
        underRst <= 1'b0;
        wt(4);
        lines(L_ACT);
        node.setTxd(1'b0);
        wt(4);
        lines(L_MID);
        node.setTxd(1'b1);
        wt(4);
        lines(L_ACT);
        ahb(1'b1, CTRL_IDX, 32'h23);
        wt(4);
        lines(L_MID);
        rdc("status", STAT_IDX, 8'h80, 8'h00);
        under90 <= 1'b1;
        ahb(1'b1, CTRL_IDX, 32'h21);
        wt(4);
        lines(L_MID);
        rdc("status", STAT_IDX, 8'h82, 8'h02);
        under90 <= 1'b0;
        wt(4);
        lines(L_ACT);
        done("active");
        // Leaving Active with a busy bus, then silence
        ahb(1'b1, CTRL_IDX, 32'h21);
        node.burst(3);
        chipMode <= CHIP_STANDBY;
        wt(4);
        lines(L_MID);
        rdc("status", STAT_IDX, 8'h08, 8'h00);
        wt(SIL);
        lines(L_GND);
        rdc("status", STAT_IDX, 8'h08, 8'h08);
        node.burst(2);
        wt(4);
        lines(L_MID);
        wt(SIL);
        lines(L_GND);
        chipMode <= CHIP_NORMAL;
        wt(4);
        lines(L_ACT);
        ahb(1'b1, CTRL_IDX, 32'h20);
        wt(4);
        lines(L_GND);
        done("silence");
        // Wake pattern: disabled, selective, then standard
        chipMode <= CHIP_SLEEP;
        for (int i = 0; i < 3; i++) begin
            ahb(1'b1, WAKE_IDX, {24'h0, WK[i]});
            ahb(1'b1, CTRL_IDX, {24'h0, WC[i]});
            wt(SIL);
            supBase = nSup;
            wakeBase = nWake;
            node.wake(60);
            wt(4);
            chk("rxLow", 32'(busCtl.rxDriveLow), 32'(WHIT[i]));
            chk("supply", 32'(nSup - supBase), 32'(WHIT[i]));
            chk("wakeReq", 32'(nWake - wakeBase), 32'(WHIT[i]));
            rdc("wake", WAKE_IDX, 8'h01, {7'h0, WHIT[i]});
        end
        lines(L_MID);
        ahb(1'b1, WAKE_IDX, 32'h3);
        rdc("wake", WAKE_IDX, 8'h03, 8'h02);
        chk("rxLow", 32'(busCtl.rxDriveLow), 32'h0);
        done("wake");
        // Battery loss and overtemperature
        batUnder <= 1'b1;
        wt(4);
        lines(L_OFF);
        batUnder <= 1'b0;
        wt(4);
        lines(L_GND);
        chipMode <= CHIP_OVERTEMP;
        wt(4);
        lines(L_OFF);
        chipMode <= CHIP_RESET;
        wt(4);
        lines(L_GND);
        done("off");
        close_out();
    end
endmodule
